// file: dv/spc_far_end.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// spc_far_end: outside partner, a master towards a slave port
// and a loop-back slave towards a master port
module spc_far_end (
   input wire logic clk,
   input wire logic cpol,
   input wire logic mst,
   input wire logic sdo,
   input wire logic sdo_oe,
   output var logic sck,
   output var logic ss_n,
   output var logic sdi
);
   logic fr_q;
   // quiet lines at time zero
   initial begin
      sck = 1'b0;
      ss_n = 1'b1;
      sdi = 1'b0;
      fr_q = 1'b0;
   end
   // clock stands at idle outside frames; released data keeps moving
   always @(posedge clk) begin
      if (!fr_q)
         sck <= cpol;
      if (mst)
         sdi <= sdo_oe ? sdo : ~sdi;
   end
   // one byte msb first, eight clocks per step, three steps per bit
   task automatic send(input logic [7:0] b, input logic sel);
      int i;
      @(posedge clk);
      fr_q <= 1'b1;
      ss_n <= ~sel;
      for (i = 7; i >= 0; i--) begin
         repeat (8) @(posedge clk);
         sdi <= b[i];
         repeat (8) @(posedge clk);
         sck <= ~cpol;
         repeat (8) @(posedge clk);
         sck <= cpol;
      end
      repeat (8) @(posedge clk);
      ss_n <= 1'b1;
      sdi <= ~sdi;
      fr_q <= 1'b0;
   endtask : send
endmodule : spc_far_end
`default_nettype wire

// file: dv/spc_top_properties.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// spc_top_properties: port checks of the serial port control
module spc_top_properties (
   input wire logic clk,
   input wire logic rst,
   input wire logic [2:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [7:0] rdata,
   input wire logic sck_o,
   input wire logic sck_oe,
   input wire logic sdo_oe,
   input wire logic ss_n_i,
   input wire logic port_pins_owned,
   input wire logic ss_pin_owned
);
   logic [7:0] ctl_q;
   logic [2:0] wcnt_q;
   logic rdc_q;
   logic ov_q;
   logic sck_p_q;
   logic [7:0] hold_q;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // control shadow, settle count, overflow seen, sck hold count
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctl_q <= 8'h00;
         wcnt_q <= 3'h0;
         rdc_q <= 1'b0;
         ov_q <= 1'b0;
         sck_p_q <= 1'b0;
         hold_q <= 8'h00;
      end else begin
         rdc_q <= rd && addr == spc_pkg::ADDR_CTRL;
         sck_p_q <= sck_o;
         if (wr && addr == spc_pkg::ADDR_CTRL) begin
            ctl_q <= wdata;
            wcnt_q <= 3'h0;
         end else if (wcnt_q != 3'h7)
            wcnt_q <= wcnt_q + 3'h1;
         if (wr && addr == spc_pkg::ADDR_CTRL && !wdata[6])
            ov_q <= 1'b0;
         else if (rdc_q && rdata[6])
            ov_q <= 1'b1;
         if (sck_o != sck_p_q)
            hold_q <= 8'h00;
         else if (hold_q != 8'hff)
            hold_q <= hold_q + 8'h01;
      end
   end
   // ==========================================================
   // assertions
   sequence s_ctrl_wr;
      wr && addr == spc_pkg::ADDR_CTRL;
   endsequence
   a_pins_follow_en: assert property (s_ctrl_wr |-> ##2
      port_pins_owned == ctl_q[5]) else $error("pin ownership wrong");
   a_ss_pin_owned: assert property (s_ctrl_wr |-> ##2
      ss_pin_owned == (ctl_q[5] && ctl_q[3:0] != 4'h5))
      else $error("select pin ownership wrong");
   a_pins_released: assert property (!port_pins_owned &&
      wcnt_q >= 3'h2 |-> !sck_oe && !sdo_oe) else $error("drives pins");
   a_idle_level: assert property ($rose(sck_oe) |->
      sck_o == ctl_q[4]) else $error("idle clock level wrong");
   a_fast_rate: assert property ($changed(sck_o) && sck_oe &&
      wcnt_q >= 3'h2 && ctl_q[3:0] == 4'h1 |=> $stable(sck_o) [*7])
      else $error("fast bit clock too quick");
   a_slow_rate: assert property ($changed(sck_o) && sck_oe &&
      wcnt_q >= 3'h2 && ctl_q[3:0] == 4'h2 |-> hold_q >= 8'h1f)
      else $error("slow bit clock too quick");
   a_master_no_ov: assert property (rd && !ov_q && ctl_q[5] &&
      addr == spc_pkg::ADDR_CTRL && ctl_q[3:0] inside {4'h1, 4'h2, 4'h3}
      |=> !rdata[6]) else $error("overflow raised as master");
   a_ov_sticky: assert property (rd && ov_q &&
      addr == spc_pkg::ADDR_CTRL |=> rdata[6]) else $error("ov lost");
   a_reserved_quiet: assert property (sck_oe && wcnt_q >= 3'h2 |->
      ctl_q[5] && ctl_q[3:0] inside {4'h1, 4'h2, 4'h3})
      else $error("clock driven outside master modes");
   a_select_drives: assert property ($fell(ss_n_i) &&
      ctl_q[5:0] == 6'h24 |-> ##[2:6] sdo_oe) else $error("no sdo drive");
   a_free_select: assert property (ctl_q[5:0] == 6'h25 &&
      wcnt_q >= 3'h4 |-> sdo_oe) else $error("select not ignored");
endmodule : spc_top_properties
bind spc_top spc_top_properties u_props (
   .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
   .rdata(rdata), .sck_o(sck_o), .sck_oe(sck_oe), .sdo_oe(sdo_oe),
   .ss_n_i(ss_n_i), .port_pins_owned(port_pins_owned),
   .ss_pin_owned(ss_pin_owned)
);
`default_nettype wire

// file: dv/spi_port_control_and_overflow_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// spi_port_control_and_overflow_tb_top: register level bench
module spi_port_control_and_overflow_tb_top;
   logic clk, rst, wr, rd, tmr, cpol, mst;
   logic [2:0] addr, tdiv;
   logic [7:0] wdata, rdata;
   logic irq, sck_o, sck_oe, sdo_o, sdo_oe, own, ss_own;
   logic sck_f, ss_n, sdi, sck_w;
   int errors, compares, cyc;
   // sck pin level from both drivers
   assign sck_w = sck_oe ? sck_o : sck_f;
   spc_top dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .irq(irq),
      .timer_two_output(tmr), .sck_i(sck_w), .sck_o(sck_o),
      .sck_oe(sck_oe), .sdo_o(sdo_o), .sdo_oe(sdo_oe), .sdi_i(sdi),
      .ss_n_i(ss_n), .port_pins_owned(own), .ss_pin_owned(ss_own));
   spc_far_end far (.clk(clk), .cpol(cpol), .mst(mst), .sdo(sdo_o),
      .sdo_oe(sdo_oe), .sck(sck_f), .ss_n(ss_n), .sdi(sdi));
   // clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // timer pulse every six clocks, and the run limit
   always @(posedge clk) begin
      tdiv <= (tdiv == 3'h5) ? 3'h0 : tdiv + 3'h1;
      tmr <= (tdiv == 3'h0);
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         errors++;
         close_out();
      end
   end
   // ==========================================================
   // tasks
   task automatic close_out();
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : close_out
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("FAIL %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wreg(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wreg
   // read strobe one cycle, data taken in the following cycle
   task automatic rchk(input logic [2:0] a, input logic [7:0] m,
                       input logic [7:0] e);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(rdata & m, e);
   endtask : rchk
   // poll busy under a bounded count
   task automatic idle_wait();
      int n;
      n = 0;
      do begin
         @(posedge clk);
         rd <= 1'b1;
         addr <= spc_pkg::ADDR_STAT;
         @(posedge clk);
         rd <= 1'b0;
         #1 n++;
      end while (rdata[1] !== 1'b0 && n < 1000);
      chk({7'h0, rdata[1]}, 8'h00);
   endtask : idle_wait
   // ==========================================================
   // main sequence
   initial begin
      int k;
      logic [3:0] m;
      rst = 1'b1; wr = 1'b0; rd = 1'b0; addr = 3'h0; wdata = 8'h00;
      cpol = 1'b0; mst = 1'b1; tdiv = 3'h0; tmr = 1'b0; cyc = 0;
      errors = 0;
      compares = 0;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rchk(spc_pkg::ADDR_CTRL, 8'hff, 8'h00);
      rchk(spc_pkg::ADDR_IMASK, 8'hff, 8'h00);
      rchk(3'h7, 8'hff, 8'h00);
      chk({7'h0, own}, 8'h00);
      // every master mode, idle level alternating
      for (k = 1; k <= 3; k++) begin
         m = k[3:0];
         wreg(spc_pkg::ADDR_CTRL, {3'h1, k[0], m});
         repeat (40) @(posedge clk);
         chk({7'h0, sck_o}, {7'h0, k[0]});
         chk({6'h0, own, sck_oe}, 8'h03);
         wreg(spc_pkg::ADDR_BUF, 8'h96 ^ {4'h0, m});
         idle_wait();
         rchk(spc_pkg::ADDR_BUF, 8'hff, 8'h96 ^ {4'h0, m});
      end
      // collision drops the second byte; master never overflows
      wreg(spc_pkg::ADDR_CTRL, 8'h21);
      repeat (40) @(posedge clk);
      wreg(spc_pkg::ADDR_BUF, 8'h3c);
      wreg(spc_pkg::ADDR_BUF, 8'hc3);
      idle_wait();
      rchk(spc_pkg::ADDR_CTRL, 8'hc0, 8'h80);
      rchk(spc_pkg::ADDR_ISTAT, 8'h07, 8'h05);
      wreg(spc_pkg::ADDR_BUF, 8'h5a);
      idle_wait();
      rchk(spc_pkg::ADDR_CTRL, 8'h40, 8'h00);
      rchk(spc_pkg::ADDR_BUF, 8'hff, 8'h5a);
      wreg(spc_pkg::ADDR_CTRL, 8'h21);
      rchk(spc_pkg::ADDR_CTRL, 8'h80, 8'h00);
      // reserved codes start nothing
      for (k = 6; k <= 16; k++) begin
         m = k[3:0];
         wreg(spc_pkg::ADDR_CTRL, {4'h2, m});
         repeat (10) @(posedge clk);
         wreg(spc_pkg::ADDR_BUF, 8'hff);
         repeat (20) @(posedge clk);
         rchk(spc_pkg::ADDR_STAT, 8'h02, 8'h00);
         chk({7'h0, sck_oe}, 8'h00);
      end
      // selected slave: second byte overflows, irq masked and cleared
      mst <= 1'b0;
      wreg(spc_pkg::ADDR_CTRL, 8'h24);
      wreg(spc_pkg::ADDR_IMASK, 8'h02);
      repeat (40) @(posedge clk);
      far.send(8'ha1, 1'b1);
      repeat (10) @(posedge clk);
      rchk(spc_pkg::ADDR_STAT, 8'h01, 8'h01);
      far.send(8'h7e, 1'b1);
      repeat (10) @(posedge clk);
      rchk(spc_pkg::ADDR_CTRL, 8'h40, 8'h40);
      rchk(spc_pkg::ADDR_ISTAT, 8'h07, 8'h07);
      chk({7'h0, irq}, 8'h01);
      rchk(spc_pkg::ADDR_BUF, 8'hff, 8'ha1);
      rchk(spc_pkg::ADDR_CTRL, 8'h40, 8'h40);
      wreg(spc_pkg::ADDR_IMASK, 8'h00);
      repeat (3) @(posedge clk);
      chk({7'h0, irq}, 8'h00);
      wreg(spc_pkg::ADDR_IMASK, 8'h02);
      repeat (3) @(posedge clk);
      chk({7'h0, irq}, 8'h01);
      wreg(spc_pkg::ADDR_ISTAT, 8'h02);
      wreg(spc_pkg::ADDR_CTRL, 8'h24);
      repeat (3) @(posedge clk);
      chk({7'h0, irq}, 8'h00);
      rchk(spc_pkg::ADDR_CTRL, 8'h40, 8'h00);
      // deselected slave takes nothing; select-free mode takes it
      far.send(8'h11, 1'b0);
      repeat (10) @(posedge clk);
      rchk(spc_pkg::ADDR_STAT, 8'h01, 8'h00);
      wreg(spc_pkg::ADDR_CTRL, 8'h25);
      repeat (40) @(posedge clk);
      chk({7'h0, ss_own}, 8'h00);
      far.send(8'h5c, 1'b0);
      repeat (10) @(posedge clk);
      rchk(spc_pkg::ADDR_BUF, 8'hff, 8'h5c);
      // disable hands every pin back
      wreg(spc_pkg::ADDR_CTRL, 8'h05);
      repeat (3) @(posedge clk);
      chk({4'h0, own, ss_own, sck_oe, sdo_oe}, 8'h00);
      close_out();
   end
endmodule : spi_port_control_and_overflow_tb_top
`default_nettype wire

// file: rtl/spc_bitclk.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// spc_bitclk: one tick per half bit period in master modes
module spc_bitclk (
   input wire logic clk,
   input wire logic rst,
   spc_clk_if.gen ck
);
   logic [5:0] cnt_q;
   logic tick_q;
   logic [5:0] half_lim;
   // half period length of the selected oscillator divider
   always_comb begin
      if (ck.mode == spc_pkg::MODE_MST_64) begin
         half_lim = 6'(spc_pkg::HALF_SLOW - 1);
      end else begin
         half_lim = 6'(spc_pkg::HALF_FAST - 1);
      end
   end
   // divider counter and tick
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_q <= 6'h00;
         tick_q <= 1'b0;
      end else if (!ck.run) begin
         cnt_q <= 6'h00;
         tick_q <= 1'b0;
      end else if (ck.mode == spc_pkg::MODE_MST_T2) begin
         cnt_q <= 6'h00;
         tick_q <= ck.t2_pulse;
      end else if (cnt_q == half_lim) begin
         cnt_q <= 6'h00;
         tick_q <= 1'b1;
      end else begin
         cnt_q <= cnt_q + 6'h01;
         tick_q <= 1'b0;
      end
   end
   assign ck.tick = tick_q;
endmodule : spc_bitclk
`default_nettype wire

// file: rtl/spc_clk_if.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// bit clock request and half-period tick
interface spc_clk_if;
   logic [3:0] mode;
   logic run;
   logic t2_pulse;
   logic tick;
   modport gen (input mode, input run, input t2_pulse, output tick);
   modport use_side (output mode, output run, output t2_pulse,
                     input tick);
endinterface : spc_clk_if
`default_nettype wire

// file: rtl/spc_pkg.sv
// ==========================================================
// spc_pkg: shared constants of the serial port control
package spc_pkg;
   // ==========================================================
   // data and timing
   localparam int DATA_W = 8;
   localparam int FOSC_HZ = 100_000_000;
   localparam int DIV_FAST = 16;
   localparam int DIV_SLOW = 64;
   localparam int HALF_FAST = DIV_FAST / 2;
   localparam int HALF_SLOW = DIV_SLOW / 2;
   localparam logic [2:0] LAST_BIT = 3'h7;
   localparam logic [3:0] LAST_HALF = 4'hf;
   // ==========================================================
   // register offsets
   localparam logic [2:0] ADDR_CTRL = 3'h0;
   localparam logic [2:0] ADDR_BUF = 3'h1;
   localparam logic [2:0] ADDR_STAT = 3'h2;
   localparam logic [2:0] ADDR_ISTAT = 3'h3;
   localparam logic [2:0] ADDR_IMASK = 3'h4;
   // ==========================================================
   // control fields and reset values
   localparam int CTRL_WRITE_COLLISION_FLAG = 7;
   localparam int CTRL_OV = 6;
   localparam int CTRL_EN = 5;
   localparam int CTRL_CKP = 4;
   localparam int IRQ_RX = 0;
   localparam int IRQ_OV = 1;
   localparam int IRQ_WRITE_COLLISION_FLAG = 2;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [2:0] IMASK_RST = 3'h0;
   // ==========================================================
   // mode field encodings
   localparam logic [3:0] MODE_SLV_NOSS = 4'h5;
   localparam logic [3:0] MODE_SLV_SS = 4'h4;
   localparam logic [3:0] MODE_MST_T2 = 4'h3;
   localparam logic [3:0] MODE_MST_64 = 4'h2;
   localparam logic [3:0] MODE_MST_16 = 4'h1;
   // master modes
   function automatic logic is_master(input logic [3:0] m);
      is_master = (m == MODE_MST_T2) || (m == MODE_MST_64) ||
                  (m == MODE_MST_16);
   endfunction : is_master
   // slave modes
   function automatic logic is_slave(input logic [3:0] m);
      is_slave = (m == MODE_SLV_NOSS) || (m == MODE_SLV_SS);
   endfunction : is_slave
endpackage : spc_pkg

// file: rtl/spc_top.sv
// Design decisions made here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module spc_top (
   input wire logic clk,
   input wire logic rst,
   input wire logic [2:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   output logic irq,
   input wire logic timer_two_output,
   input wire logic sck_i,
   output logic sck_o,
   output logic sck_oe,
   output logic sdo_o,
   output logic sdo_oe,
   input wire logic sdi_i,
   input wire logic ss_n_i,
   output logic port_pins_owned,
   output logic ss_pin_owned
);
   // ==========================================================
   // declarations
   typedef enum logic {SPC_IDLE, SPC_SHIFT} spc_state_t;
   spc_state_t state_q;
   logic [7:0] ctrl_q;
   logic [7:0] serial_buffer_q;
   logic [7:0] serial_shift_register_q;
   logic buf_full_q;
   logic [2:0] istat_q;
   logic [2:0] imask_q;
   logic [7:0] rdata_q;
   logic irq_q;
   logic [2:0] bit_cnt_q;
   logic sample_q;
   logic sck_q;
   logic sck_oe_q;
   logic sdo_q;
   logic sdo_oe_q;
   logic pins_q;
   logic ss_own_q;
   logic [2:0] sck_sync_q;
   logic [2:0] sdi_sync_q;
   logic [2:0] ss_sync_q;
   logic sck_f_q;
   logic sdi_f_q;
   logic ss_f_q;
   logic sck_prev_q;
   logic port_enable;
   logic idle_clock_polarity;
   logic [3:0] port_mode_select;
   logic master;
   logic slave;
   logic selected;
   logic busy;
   logic lead_ev;
   logic trail_ev;
   logic done;
   logic ovf_ev;
   logic load_ev;
   logic write_collision_flag_ev;
   logic wr_ctrl;
   logic wr_buf;
   logic rd_buf;
   logic start_mst;
   logic [7:0] shifted;
   spc_clk_if ck ();
   // ==========================================================
   // control field decode
   assign port_enable = ctrl_q[spc_pkg::CTRL_EN];
   assign idle_clock_polarity = ctrl_q[spc_pkg::CTRL_CKP];
   assign port_mode_select = ctrl_q[3:0];
   // reserved codes are neither master nor slave
   assign master = port_enable &&
                   spc_pkg::is_master(port_mode_select);
   assign slave = port_enable &&
                  spc_pkg::is_slave(port_mode_select);
   // select line only gates the slave in mode 0100
   assign selected = slave &&
      ((port_mode_select == spc_pkg::MODE_SLV_NOSS) ||
       !ss_f_q);
   // ==========================================================
   // bus strobes
   assign wr_ctrl = wr && (addr == spc_pkg::ADDR_CTRL);
   assign wr_buf = wr && (addr == spc_pkg::ADDR_BUF);
   assign rd_buf = rd && (addr == spc_pkg::ADDR_BUF);
   assign busy = (state_q == SPC_SHIFT);
   assign write_collision_flag_ev = wr_buf && busy;
   assign start_mst = wr_buf && !busy && master;
   // ==========================================================
   // bit clock generator
   assign ck.mode = port_mode_select;
   assign ck.run = master && busy;
   assign ck.t2_pulse = timer_two_output;
   spc_bitclk u_bitclk (
      .clk (clk),
      .rst (rst),
      .ck (ck)
   );
   // ==========================================================
   // pin synchronisers: three stages, change when 2 and 3 agree
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sck_sync_q <= 3'h0;
         sdi_sync_q <= 3'h0;
         ss_sync_q <= 3'h7;
      end else begin
         sck_sync_q <= {sck_sync_q[1:0], sck_i};
         sdi_sync_q <= {sdi_sync_q[1:0], sdi_i};
         ss_sync_q <= {ss_sync_q[1:0], ss_n_i};
      end
   end
   // filtered pin levels
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sck_f_q <= 1'b0;
         sdi_f_q <= 1'b0;
         ss_f_q <= 1'b1;
      end else begin
         if (sck_sync_q[1] == sck_sync_q[2]) begin
            sck_f_q <= sck_sync_q[2];
         end
         if (sdi_sync_q[1] == sdi_sync_q[2]) begin
            sdi_f_q <= sdi_sync_q[2];
         end
         if (ss_sync_q[1] == ss_sync_q[2]) begin
            ss_f_q <= ss_sync_q[2];
         end
      end
   end
   // previous filtered clock for edge detection
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sck_prev_q <= 1'b0;
      end else begin
         sck_prev_q <= sck_f_q;
      end
   end
   // ==========================================================
   // edge events: leading leaves idle level, trailing returns
   always_comb begin
      lead_ev = 1'b0;
      trail_ev = 1'b0;
      if (master && busy && ck.tick) begin
         lead_ev = (sck_q == idle_clock_polarity);
         trail_ev = (sck_q != idle_clock_polarity);
      end else if (selected && (sck_f_q != sck_prev_q)) begin
         lead_ev = (sck_prev_q == idle_clock_polarity);
         trail_ev = (sck_prev_q != idle_clock_polarity);
      end
   end
   assign shifted = {serial_shift_register_q[6:0], sample_q};
   assign done = trail_ev && (bit_cnt_q == spc_pkg::LAST_BIT);
   // slave byte into unread buffer is an overflow
   assign ovf_ev = done && slave && buf_full_q && !rd_buf;
   assign load_ev = done && !ovf_ev;
   // ==========================================================
   // transfer state
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_q <= SPC_IDLE;
      end else if (!master && !selected) begin
         state_q <= SPC_IDLE;
      end else if (done) begin
         state_q <= SPC_IDLE;
      end else if (start_mst || (selected && lead_ev)) begin
         state_q <= SPC_SHIFT;
      end
   end
   // bit counter, one step per trailing edge
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         bit_cnt_q <= 3'h0;
      end else if ((!master && !selected) || start_mst) begin
         bit_cnt_q <= 3'h0;
      end else if (trail_ev) begin
         bit_cnt_q <= bit_cnt_q + 3'h1;
      end
   end
   // input sample on leading edge
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sample_q <= 1'b0;
      end else if (lead_ev) begin
         sample_q <= sdi_f_q;
      end
   end
   // shift register: load on idle write, shift on trailing edge
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         serial_shift_register_q <= 8'h00;
      end else if (wr_buf && !busy) begin
         serial_shift_register_q <= wdata;
      end else if (trail_ev) begin
         serial_shift_register_q <= shifted;
      end
   end
   // receive buffer and full flag, load wins over read
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         serial_buffer_q <= 8'h00;
         buf_full_q <= 1'b0;
      end else begin
         if (load_ev) begin
            serial_buffer_q <= shifted;
         end
         buf_full_q <= load_ev || (buf_full_q && !rd_buf);
      end
   end
   // ==========================================================
   // control register; flags set by hardware, cleared by zero
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl_q <= spc_pkg::CTRL_RST;
      end else begin
         if (wr_ctrl) begin
            ctrl_q[5:0] <= wdata[5:0];
         end
         ctrl_q[spc_pkg::CTRL_OV] <= ovf_ev ||
            (ctrl_q[spc_pkg::CTRL_OV] &&
             !(wr_ctrl && !wdata[spc_pkg::CTRL_OV]));
         ctrl_q[spc_pkg::CTRL_WRITE_COLLISION_FLAG] <= write_collision_flag_ev ||
            (ctrl_q[spc_pkg::CTRL_WRITE_COLLISION_FLAG] &&
             !(wr_ctrl && !wdata[spc_pkg::CTRL_WRITE_COLLISION_FLAG]));
      end
   end
   // ==========================================================
   // interrupt status (write one to clear, set wins) and mask
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         istat_q <= 3'h0;
         imask_q <= spc_pkg::IMASK_RST;
      end else begin
         if (wr && (addr == spc_pkg::ADDR_IMASK)) begin
            imask_q <= wdata[2:0];
         end
         istat_q[spc_pkg::IRQ_RX] <= load_ev ||
            (istat_q[spc_pkg::IRQ_RX] &&
             !(wr && (addr == spc_pkg::ADDR_ISTAT) &&
               wdata[spc_pkg::IRQ_RX]));
         istat_q[spc_pkg::IRQ_OV] <= ovf_ev ||
            (istat_q[spc_pkg::IRQ_OV] &&
             !(wr && (addr == spc_pkg::ADDR_ISTAT) &&
               wdata[spc_pkg::IRQ_OV]));
         istat_q[spc_pkg::IRQ_WRITE_COLLISION_FLAG] <= write_collision_flag_ev ||
            (istat_q[spc_pkg::IRQ_WRITE_COLLISION_FLAG] &&
             !(wr && (addr == spc_pkg::ADDR_ISTAT) &&
               wdata[spc_pkg::IRQ_WRITE_COLLISION_FLAG]));
      end
   end
   // level interrupt while any unmasked status bit is set
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(istat_q & imask_q);
      end
   end
   // ==========================================================
   // read data, one cycle after the strobe, zero otherwise
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata_q <= 8'h00;
      end else if (rd) begin
         case (addr)
            spc_pkg::ADDR_CTRL: begin
               rdata_q <= ctrl_q;
            end
            spc_pkg::ADDR_BUF: begin
               rdata_q <= serial_buffer_q;
            end
            spc_pkg::ADDR_STAT: begin
               rdata_q <= {6'h00, busy, buf_full_q};
            end
            spc_pkg::ADDR_ISTAT: begin
               rdata_q <= {5'h00, istat_q};
            end
            spc_pkg::ADDR_IMASK: begin
               rdata_q <= {5'h00, imask_q};
            end
            default: begin
               rdata_q <= 8'h00;
            end
         endcase
      end else begin
         rdata_q <= 8'h00;
      end
   end
   // ==========================================================
   // serial clock output, idle level from polarity bit
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sck_q <= 1'b0;
      end else if (master && busy) begin
         if (lead_ev || trail_ev) begin
            sck_q <= !sck_q;
         end
      end else begin
         sck_q <= idle_clock_polarity;
      end
   end
   // data output follows shift register msb
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sdo_q <= 1'b0;
      end else if (wr_buf && !busy) begin
         sdo_q <= wdata[7];
      end else if (trail_ev) begin
         sdo_q <= shifted[7];
      end else if (!busy) begin
         sdo_q <= serial_shift_register_q[7];
      end
   end
   // ==========================================================
   // pin ownership and drive enables
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pins_q <= 1'b0;
         ss_own_q <= 1'b0;
         sck_oe_q <= 1'b0;
         sdo_oe_q <= 1'b0;
      end else begin
         pins_q <= port_enable;
         ss_own_q <= port_enable &&
            (port_mode_select != spc_pkg::MODE_SLV_NOSS);
         sck_oe_q <= master;
         sdo_oe_q <= master || selected;
      end
   end
   // ==========================================================
   // outputs
   assign rdata = rdata_q;
   assign irq = irq_q;
   assign sck_o = sck_q;
   assign sck_oe = sck_oe_q;
   assign sdo_o = sdo_q;
   assign sdo_oe = sdo_oe_q;
   assign port_pins_owned = pins_q;
   assign ss_pin_owned = ss_own_q;
endmodule : spc_top
`default_nettype wire
